// ===== hw/pix_pkg.sv
// Overview of operation
// - On the 8-bit or serial path a 65k pixel is two bytes (C4..C0,B5..B3 then B2..B0,A4..A0) and a 262k pixel is three bytes C, B, A on D5..D0.
// - On a 16-bit bus a 65k pixel is one word C,B,A on D15..D0; 262k format 1 is C on D5..D0 then B on D13..D8 with A on D5..D0.
// - On a 16-bit bus 262k format 2 packs two pixels in three words on lanes D13..D8 and D5..D0, ignoring D15, D14, D7 and D6.
// - On the 18-bit bus a 262k pixel is one word with C on D17..D12, B on D11..D6 and A on D5..D0; unused lines are ignored.
// - Memory reads return pixels with the same count, order and placement as writes, unused lines being don't-care.
// - All configuration returns to defaults once the minimum reset pulse has elapsed.
// - The panel drive outputs turn on 200 ms after the display-on command.
// - The bus type is set by bus_sel_pins[1] (bus_sel_pins[0] is unused) and two high bits from a command reset to 00.
// - A two-bit colour-depth field gives 65k for 00/01 (reset), 262k for 10 and 262k format 2 for 11.
package pix_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RESET_PULSE_NS  = 2000;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ON_DELAY_MS     = 200;
  localparam int unsigned ON_DELAY_CYC    = ON_DELAY_MS * (CLK_HZ / 1000);

  localparam logic [7:0] CMD_WRITE_RAM   = 8'h5C;
  localparam logic [7:0] CMD_READ_RAM    = 8'h5D;
  localparam logic [7:0] CMD_REMAP       = 8'hA0;
  localparam logic [7:0] CMD_FUNC_SEL    = 8'hAB;
  localparam logic [7:0] DISPLAY_OFF_CMD = 8'hAE;
  localparam logic [7:0] DISPLAY_ON_CMD  = 8'hAF;

  localparam logic [1:0] DEPTH_RESET    = 2'h0;
  localparam logic [1:0] BUS_HI_RESET   = 2'h0;
  localparam logic [1:0] DEPTH_262K     = 2'h2;
  localparam logic [1:0] DEPTH_262K_F2  = 2'h3;
  localparam logic [1:0] BUS_HI_16      = 2'h1;
  localparam logic [1:0] BUS_HI_18      = 2'h3;
  localparam logic [1:0] BUS_LO_8080    = 2'h2;
  localparam int unsigned DEPTH_MSB     = 7;
  localparam int unsigned BUSW_MSB      = 7;
  localparam int unsigned ADDR_W        = 14;

  typedef enum logic [1:0] {W8, W16, W18} width_t;
  typedef enum {PIX_IDLE, PIX_WRITE, PIX_READ, PIX_PARAM} mode_t;
endpackage

// ===== hw/pix_ram.sv
`timescale 1ns/1ps
module pix_ram
  import pix_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [17:0]       wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [17:0]       rdata_ff
);
  logic [17:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata_ff <= mem[raddr];
  end
endmodule // pix_ram

// ===== hw/pix_port.sv
`timescale 1ns/1ps
module pix_port
  import pix_pkg::*;
#(
  parameter int unsigned ON_DELAY = ON_DELAY_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hw_reset_low,
  input  wire logic [1:0]  bus_sel_pins,
  input  wire logic        dc_sel,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [17:0] data_in,
  output logic      [17:0] data_out_ff,
  output logic      [17:0] data_oe_ff,
  output logic             rd_valid_ff,
  output logic             panel_drive_outputs_ff,
  output logic             in_reset_ff
);
  // ----------------------------------------
  // Reset pin synchroniser and pulse filter
  // ----------------------------------------
  logic [2:0]  rs_sync_ff;
  logic        rs_low_ff;
  logic [7:0]  rs_cnt_ff;
  logic        cfg_rst;
  logic [2:0]  bs_sync_ff;
  logic        bs_par_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rs_sync_ff  <= 3'h7;
      rs_low_ff   <= 1'b0;
      in_reset_ff <= 1'b1;
      bs_sync_ff  <= 3'h0;
      bs_par_ff   <= 1'b0;
    end else begin
      rs_sync_ff  <= {rs_sync_ff[1:0], hw_reset_low};
      bs_sync_ff  <= {bs_sync_ff[1:0], bus_sel_pins[1]};
      in_reset_ff <= rs_low_ff;
      if (rs_sync_ff[2] == rs_sync_ff[1]) begin
        rs_low_ff <= ~rs_sync_ff[1];
      end
      if (bs_sync_ff[2] == bs_sync_ff[1]) begin
        bs_par_ff <= bs_sync_ff[1];
      end
    end
  end

  // Short glitches do not reset; the full pulse width is required
  always_ff @(posedge core_clk) begin
    if (rst || !rs_low_ff) begin
      rs_cnt_ff <= 8'h00;
    end else if (rs_cnt_ff != 8'(RESET_PULSE_CYC)) begin
      rs_cnt_ff <= rs_cnt_ff + 8'h01;
    end
  end

  assign cfg_rst = rst || (rs_low_ff && rs_cnt_ff == 8'(RESET_PULSE_CYC));

  // ----------------------------------------
  // Command decode and configuration
  // ----------------------------------------
  logic [1:0] depth_ff;
  logic [1:0] bus_hi_ff;
  mode_t      mode_ff;
  logic [7:0] last_cmd_ff;
  logic       wr_act;
  logic       rd_act;
  logic       cmd_act;
  width_t     width;

  assign wr_act  = wr_stb && !rs_low_ff;
  assign rd_act  = rd_stb && !rs_low_ff;
  assign cmd_act = wr_act && !dc_sel;

  assign width = !bs_par_ff ? W8 : (bus_hi_ff == BUS_HI_16) ? W16 : (bus_hi_ff == BUS_HI_18) ? W18 : W8;

  always_ff @(posedge core_clk) begin
    if (cfg_rst) begin
      depth_ff    <= DEPTH_RESET;
      bus_hi_ff   <= BUS_HI_RESET;
      mode_ff     <= PIX_IDLE;
      last_cmd_ff <= 8'h00;
    end else if (cmd_act) begin
      last_cmd_ff <= data_in[7:0];
      case (data_in[7:0])
        CMD_WRITE_RAM: mode_ff <= PIX_WRITE;
        CMD_READ_RAM:  mode_ff <= PIX_READ;
        CMD_REMAP,
        CMD_FUNC_SEL:  mode_ff <= PIX_PARAM;
        default:       mode_ff <= PIX_IDLE;
      endcase
    end else if (wr_act && mode_ff == PIX_PARAM) begin
      if (last_cmd_ff == CMD_REMAP) begin
        depth_ff <= data_in[DEPTH_MSB -: 2];
      end else begin
        bus_hi_ff <= data_in[BUSW_MSB -: 2];
      end
      mode_ff <= PIX_IDLE;
    end
  end

  // ----------------------------------------
  // Panel drive enable after display-on
  // ----------------------------------------
  logic [23:0] on_cnt_ff;
  logic        on_pend_ff;

  always_ff @(posedge core_clk) begin
    if (cfg_rst) begin
      on_pend_ff             <= 1'b0;
      on_cnt_ff              <= 24'h000000;
      panel_drive_outputs_ff <= 1'b0;
    end else if (cmd_act && data_in[7:0] == DISPLAY_OFF_CMD) begin
      on_pend_ff             <= 1'b0;
      panel_drive_outputs_ff <= 1'b0;
    end else if (cmd_act && data_in[7:0] == DISPLAY_ON_CMD && !panel_drive_outputs_ff) begin
      on_pend_ff <= 1'b1;
      on_cnt_ff  <= 24'h000000;
    end else if (on_pend_ff) begin
      if (on_cnt_ff == 24'(ON_DELAY - 1)) begin
        on_pend_ff             <= 1'b0;
        panel_drive_outputs_ff <= 1'b1;
      end else begin
        on_cnt_ff <= on_cnt_ff + 24'h000001;
      end
    end
  end

  // ----------------------------------------
  // Write unpacking into staging
  // ----------------------------------------
  // Group length: 1..3 transfers per group; format 2 commits two pixels per three
  logic [1:0]        phase_ff;
  logic [1:0]        last_phase;
  logic [17:0]       stage_ff;
  logic [5:0]        keep_ff;
  logic              we;
  logic [17:0]       wpix;
  logic [ADDR_W-1:0] waddr_ff;
  logic [ADDR_W-1:0] raddr_ff;
  logic              pix_wr;
  logic              pix_rd;
  logic [17:0]       rdata;
  logic [5:0]        prev_a_ff;

  assign pix_wr = wr_act && dc_sel && mode_ff == PIX_WRITE;
  assign pix_rd = rd_act && dc_sel && mode_ff == PIX_READ;

  always_comb begin
    last_phase = 2'h0;
    if (width == W8) begin
      last_phase = depth_ff[1] ? 2'h2 : 2'h1;
    end else if (width == W16 && depth_ff == DEPTH_262K) begin
      last_phase = 2'h1;
    end else if (width == W16 && depth_ff == DEPTH_262K_F2) begin
      last_phase = 2'h2;
    end
  end

  // Pixels stored as 6:6:6; 65k C and A widened by repeating the top bit
  always_comb begin
    we   = 1'b0;
    wpix = stage_ff;
    if (pix_wr) begin
      case (width)
        W18: begin
          we   = 1'b1;
          wpix = data_in;
        end
        W16: begin
          if (!depth_ff[1]) begin
            we   = 1'b1;
            wpix = {data_in[15:11], data_in[15], data_in[10:5], data_in[4:0], data_in[4]};
          end else if (depth_ff == DEPTH_262K) begin
            we   = phase_ff == 2'h1;
            wpix = {stage_ff[17:12], data_in[13:8], data_in[5:0]};
          end else begin
            we = phase_ff != 2'h0;
            if (phase_ff == 2'h1) begin
              wpix = {stage_ff[17:6], data_in[13:8]};
            end else begin
              wpix = {keep_ff, data_in[13:8], data_in[5:0]};
            end
          end
        end
        default: begin
          we = phase_ff == last_phase;
          if (!depth_ff[1]) begin
            wpix = {stage_ff[17:13], stage_ff[17], stage_ff[12:10], data_in[7:5], data_in[4:0], data_in[4]};
          end else begin
            wpix = {stage_ff[17:6], data_in[5:0]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (cfg_rst || cmd_act) begin
      phase_ff <= 2'h0;
      stage_ff <= 18'h00000;
      keep_ff  <= 6'h00;
    end else if (pix_wr) begin
      phase_ff <= (phase_ff == last_phase) ? 2'h0 : phase_ff + 2'h1;
      if (width == W8 && !depth_ff[1]) begin
        stage_ff[17:10] <= data_in[7:0];
      end else if (width == W8 && phase_ff == 2'h1) begin
        stage_ff[11:6] <= data_in[5:0];
      end else if (width == W16 && depth_ff == DEPTH_262K_F2 && phase_ff == 2'h0) begin
        stage_ff[17:6] <= {data_in[13:8], data_in[5:0]};
      end else if (width == W16 && depth_ff == DEPTH_262K_F2 && phase_ff == 2'h1) begin
        keep_ff <= data_in[5:0];
      end else begin
        stage_ff[17:12] <= data_in[5:0];
      end
    end
  end

  // ----------------------------------------
  // Address counters and read packing
  // ----------------------------------------
  // Reads in format 2 mirror writes; the read phase pre-fetches next pixel
  logic [1:0] rphase_ff;
  logic       radv;

  assign radv = pix_rd && ((width == W16 && depth_ff == DEPTH_262K_F2) ? rphase_ff != 2'h1 : rphase_ff == last_phase);

  always_ff @(posedge core_clk) begin
    if (cfg_rst || cmd_act) begin
      waddr_ff  <= '0;
      raddr_ff  <= '0;
      rphase_ff <= 2'h0;
    end else begin
      if (we) begin
        waddr_ff <= waddr_ff + 1'b1;
      end
      if (pix_rd) begin
        rphase_ff <= (rphase_ff == last_phase) ? 2'h0 : rphase_ff + 2'h1;
      end
      if (radv) begin
        raddr_ff <= raddr_ff + 1'b1;
      end
    end
  end

  pix_ram u_ram (
    .core_clk (core_clk),
    .we       (we),
    .waddr    (waddr_ff),
    .wdata    (wpix),
    .raddr    (raddr_ff),
    .rdata_ff (rdata)
  );

  always_ff @(posedge core_clk) begin
    if (cfg_rst) begin
      data_out_ff <= 18'h00000;
      data_oe_ff  <= 18'h00000;
      rd_valid_ff <= 1'b0;
      prev_a_ff   <= 6'h00;
    end else begin
      rd_valid_ff <= pix_rd;
      data_oe_ff  <= pix_rd ? 18'h3FFFF : 18'h00000;
      if (pix_rd) begin
        data_out_ff <= 18'h00000;
        case (width)
          W18: data_out_ff <= rdata;
          W16: begin
            if (!depth_ff[1]) begin
              data_out_ff[15:0] <= {rdata[17:13], rdata[11:6], rdata[5:1]};
            end else if (depth_ff == DEPTH_262K) begin
              data_out_ff[13:0] <= (rphase_ff == 2'h0) ? {8'h00, rdata[17:12]}
                                                      : {rdata[11:6], 2'h0, rdata[5:0]};
            end else if (rphase_ff == 2'h0) begin
              data_out_ff[13:0] <= {rdata[17:12], 2'h0, rdata[11:6]};
              prev_a_ff         <= rdata[5:0];
            end else if (rphase_ff == 2'h1) begin
              data_out_ff[13:0] <= {prev_a_ff, 2'h0, rdata[17:12]};
            end else begin
              data_out_ff[13:0] <= {rdata[11:6], 2'h0, rdata[5:0]};
            end
          end
          default: begin
            if (!depth_ff[1]) begin
              data_out_ff[7:0] <= (rphase_ff == 2'h0) ? {rdata[17:13], rdata[11:9]}
                                                     : {rdata[8:6], rdata[5:1]};
            end else begin
              data_out_ff[5:0] <= (rphase_ff == 2'h0) ? rdata[17:12]
                                : (rphase_ff == 2'h1) ? rdata[11:6] : rdata[5:0];
            end
          end
        endcase
      end
    end
  end
endmodule // pix_port

// ===== test/pix_port_monitor.sv
`timescale 1ns/1ps
module pix_port_monitor
  import pix_pkg::*;
#(
  parameter int unsigned ON_DELAY = ON_DELAY_CYC
)(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        hw_reset_low,
  input wire logic        dc_sel,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [17:0] data_in,
  input wire logic [17:0] data_out_ff,
  input wire logic [17:0] data_oe_ff,
  input wire logic        rd_valid_ff,
  input wire logic        panel_drive_outputs_ff,
  input wire logic        in_reset_ff
);
  logic        on_take;
  logic        off_take;
  logic [31:0] on_cnt_ff;
  logic [7:0]  low_cnt_ff;

  assign on_take  = wr_stb && !dc_sel && !in_reset_ff && data_in[7:0] == DISPLAY_ON_CMD;
  assign off_take = wr_stb && !dc_sel && !in_reset_ff && data_in[7:0] == DISPLAY_OFF_CMD;

  // Only a display-on that finds the panel dark starts the count; display-off drops it
  always_ff @(posedge core_clk) begin
    if (rst || in_reset_ff || panel_drive_outputs_ff || off_take) on_cnt_ff <= 32'h0;
    else if (on_take && on_cnt_ff == 32'h0) on_cnt_ff <= 32'h1;
    else if (on_cnt_ff != 32'h0) on_cnt_ff <= on_cnt_ff + 32'h1;
  end

  // Saturates so a long pin reset cannot wrap
  always_ff @(posedge core_clk) begin
    if (rst || !in_reset_ff) low_cnt_ff <= 8'h0;
    else if (low_cnt_ff != 8'hFF) low_cnt_ff <= low_cnt_ff + 8'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_valid_cause;
    rd_valid_ff |-> $past(rd_stb) && !in_reset_ff;
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("read data without strobe");
  property p_oe_follows;
    data_oe_ff == {18{rd_valid_ff}};
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("drive enable off valid");
  property p_dout_hold;
    !rd_valid_ff && !in_reset_ff && !$past(in_reset_ff) |-> $stable(data_out_ff);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("read data moved");
  property p_on_delay;
    $rose(panel_drive_outputs_ff) |-> on_cnt_ff == ON_DELAY + 1;
  endproperty
  a_on_delay: assert property (p_on_delay) else $error("panel on at wrong time");
  property p_off_cmd;
    wr_stb && !dc_sel && !in_reset_ff && data_in[7:0] == DISPLAY_OFF_CMD |=> ##[0:1] !panel_drive_outputs_ff;
  endproperty
  a_off_cmd: assert property (p_off_cmd) else $error("panel stayed on");
  property p_pin_seen;
    (!hw_reset_low) [*8] |-> in_reset_ff;
  endproperty
  a_pin_seen: assert property (p_pin_seen) else $error("pin reset missed");
  property p_reset_dark;
    low_cnt_ff > RESET_PULSE_CYC + 2 |-> !panel_drive_outputs_ff && !rd_valid_ff;
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("pin reset left state");
  property p_rst_vals;
    $past(rst) |-> !panel_drive_outputs_ff && !rd_valid_ff && data_oe_ff == 18'h0 && in_reset_ff;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
endmodule // pix_port_monitor

// ===== test/host_model.sv
`timescale 1ns/1ps
module host_model
  import pix_pkg::*;
#(
  // Scaled down from the millisecond waits to keep runs short
  parameter int unsigned SETTLE_CYC   = 50,
  parameter int unsigned CMD_WAIT_CYC = 200
)(
  input  wire logic        core_clk,
  input  wire logic        rd_valid_ff,
  input  wire logic [17:0] data_out_ff,
  output logic             hw_reset_low,
  output logic             dc_sel,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic      [17:0] data_in
);
  initial begin
    hw_reset_low = 1'b1;
    dc_sel       = 1'b1;
    wr_stb       = 1'b0;
    rd_stb       = 1'b0;
    data_in      = 18'h0;
  end

  // Released bus shows the inverse, never a stale copy
  task automatic put(input logic dc, input logic [17:0] d);
    @(negedge core_clk);
    dc_sel = dc;
    data_in = d;
    wr_stb = 1'b1;
    @(negedge core_clk);
    wr_stb = 1'b0;
    data_in = ~d;
  endtask

  task automatic get(output logic [17:0] q, output logic ok);
    @(negedge core_clk);
    dc_sel = 1'b1;
    rd_stb = 1'b1;
    @(negedge core_clk);
    rd_stb = 1'b0;
    ok = rd_valid_ff;
    q = data_out_ff;
  endtask

  task automatic pin_reset(input int low);
    hw_reset_low = 1'b0;
    repeat (low) @(negedge core_clk);
    hw_reset_low = 1'b1;
  endtask

  task automatic power_up();
    repeat (SETTLE_CYC) @(negedge core_clk);
    pin_reset(RESET_PULSE_CYC + 10);
    repeat (CMD_WAIT_CYC) @(negedge core_clk);
  endtask
endmodule // host_model

// ===== test/tb_pix_port.sv
`timescale 1ns/1ps
module tb_pix_port;
  import pix_pkg::*;
  localparam int unsigned ON_D = 20;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  bus_sel_pins = 2'h2;
  logic        hw_reset_low, dc_sel, wr_stb, rd_stb;
  logic [17:0] data_in, data_out_ff, data_oe_ff;
  logic        rd_valid_ff, panel_drive_outputs_ff, in_reset_ff;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #10 core_clk = ~core_clk;

  pix_port #(.ON_DELAY(ON_D)) uut (
    .core_clk               (core_clk),
    .rst                    (rst),
    .hw_reset_low           (hw_reset_low),
    .bus_sel_pins           (bus_sel_pins),
    .dc_sel                 (dc_sel),
    .wr_stb                 (wr_stb),
    .rd_stb                 (rd_stb),
    .data_in                (data_in),
    .data_out_ff            (data_out_ff),
    .data_oe_ff             (data_oe_ff),
    .rd_valid_ff            (rd_valid_ff),
    .panel_drive_outputs_ff (panel_drive_outputs_ff),
    .in_reset_ff            (in_reset_ff)
  );

  host_model host (
    .core_clk     (core_clk),
    .rd_valid_ff  (rd_valid_ff),
    .data_out_ff  (data_out_ff),
    .hw_reset_low (hw_reset_low),
    .dc_sel       (dc_sel),
    .wr_stb       (wr_stb),
    .rd_stb       (rd_stb),
    .data_in      (data_in)
  );

  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c);
    host.put(1'b0, {10'h000, c});
  endtask

  task automatic set_mode(input logic [1:0] pins, input logic [1:0] hi, input logic [1:0] dep);
    @(negedge core_clk);
    bus_sel_pins = pins;
    cmd(CMD_FUNC_SEL);
    host.put(1'b1, {10'h000, hi, 6'h01});
    cmd(CMD_REMAP);
    host.put(1'b1, {10'h000, dep, 6'h00});
  endtask

  task automatic wr(input int n, input logic [17:0] w [3]);
    cmd(CMD_WRITE_RAM);
    for (int i = 0; i < n; i++) host.put(1'b1, w[i]);
  endtask

  task automatic rd(input string what, input int n, input logic [17:0] e [3], input logic [17:0] m);
    logic [17:0] q;
    logic        ok;
    cmd(CMD_READ_RAM);
    for (int i = 0; i < n; i++) begin
      host.get(q, ok);
      check("valid", {17'h0, ok}, 18'h1);
      check(what, q & m, e[i] & m);
    end
  endtask

  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_wide();
    set_mode(2'h2, BUS_HI_18, DEPTH_262K);
    wr(1, '{18'h2D5B3, 18'h0, 18'h0});
    rd("w18", 1, '{18'h2D5B3, 18'h0, 18'h0}, 18'h3FFFF);
    set_mode(2'h2, BUS_HI_RESET, DEPTH_262K);
    rd("b262", 3, '{18'h2D, 18'h16, 18'h33}, 18'h3F);
    set_mode(2'h2, BUS_HI_16, DEPTH_262K);
    rd("f1", 2, '{18'h2D, 18'h1633, 18'h0}, 18'h3F3F);
    $display("done wide");
  endtask

  task automatic t_65k();
    set_mode(2'h2, BUS_HI_16, DEPTH_RESET);
    wr(1, '{18'h3B56D, 18'h0, 18'h0});
    rd("w16", 1, '{18'hB56D, 18'h0, 18'h0}, 18'hFFFF);
    set_mode(2'h2, BUS_HI_RESET, 2'h1);
    rd("b65", 2, '{18'hB5, 18'h6D, 18'h0}, 18'hFF);
    $display("done 65k");
  endtask

  task automatic t_fmt2();
    set_mode(2'h2, BUS_HI_16, DEPTH_262K_F2);
    wr(3, '{18'h3EDD6, 18'h3F3CA, 18'h3FCC5});
    set_mode(2'h2, BUS_HI_18, DEPTH_262K);
    rd("f2", 2, '{18'h2D5B3, 18'h0AF05, 18'h0}, 18'h3FFFF);
    set_mode(2'h2, BUS_HI_16, DEPTH_262K_F2);
    rd("f2r", 3, '{18'h02D16, 18'h0330A, 18'h03C05}, 18'h03F3F);
    $display("done fmt2");
  endtask

  task automatic t_partial();
    set_mode(2'h2, BUS_HI_RESET, DEPTH_RESET);
    wr(1, '{18'h0, 18'h0, 18'h0});
    set_mode(2'h2, BUS_HI_18, DEPTH_262K);
    rd("part", 1, '{18'h2D5B3, 18'h0, 18'h0}, 18'h3FFFF);
    $display("done partial");
  endtask

  task automatic t_panel();
    int i;
    i = 0;
    cmd(DISPLAY_ON_CMD);
    while (panel_drive_outputs_ff !== 1'b1 && i < 100) begin
      @(negedge core_clk);
      i++;
    end
    check("on_delay", 18'(i), 18'(ON_D));
    cmd(DISPLAY_OFF_CMD);
    repeat (2) @(negedge core_clk);
    check("off", {17'h0, panel_drive_outputs_ff}, 18'h0);
    $display("done panel");
  endtask

  task automatic t_pin();
    cmd(DISPLAY_ON_CMD);
    repeat (ON_D + 5) @(negedge core_clk);
    host.pin_reset(RESET_PULSE_CYC + 10);
    check("rst_panel", {17'h0, panel_drive_outputs_ff}, 18'h0);
    repeat (10) @(negedge core_clk);
    bus_sel_pins = 2'h0;
    wr(2, '{18'hB5, 18'h6D, 18'h0});
    rd("rst65", 2, '{18'hB5, 18'h6D, 18'h0}, 18'hFF);
    $display("done pin");
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("mismatch timeout exp done seen hang");
      stop_test();
    end
  end

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    host.power_up();
    t_wide();
    t_65k();
    t_fmt2();
    t_partial();
    t_panel();
    t_pin();
    stop_test();
  end
endmodule // tb_pix_port

bind pix_port pix_port_monitor #(.ON_DELAY(ON_DELAY)) mon (
  .core_clk               (core_clk),
  .rst                    (rst),
  .hw_reset_low           (hw_reset_low),
  .dc_sel                 (dc_sel),
  .wr_stb                 (wr_stb),
  .rd_stb                 (rd_stb),
  .data_in                (data_in),
  .data_out_ff            (data_out_ff),
  .data_oe_ff             (data_oe_ff),
  .rd_valid_ff            (rd_valid_ff),
  .panel_drive_outputs_ff (panel_drive_outputs_ff),
  .in_reset_ff            (in_reset_ff)
);
